// file: panel_pkg.sv
/*
  shared constants, types and register map of the panel setting logic.
  assumes a 200 mhz system clock and 32-bit axi4-lite register access.
*/
package panel_pkg;

  // clock and time base
  localparam int CLK_PERIOD_NS = 5;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
  localparam int SEC_MS = 1000;
  localparam int INIT_HOLD_MS = 3000;
  localparam int BACK_HOLD_MS = 1000;
  localparam int SAMPLE_MS = 250;

  // setting ranges
  localparam int ZC_THR_MAX = 99;
  localparam int RET_MAX = 99;
  localparam int PROT_MAX = 19;
  localparam int PASS_MAX = 9999;
  localparam int PASS_MIN = -1999;

  // register byte offsets
  localparam logic [11:0] SETTINGS_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] VALUE_OFS = 12'h008;

  // settings register fields
  localparam int F_ZC_EN = 0;
  localparam int F_COLOR = 4;
  localparam int F_ZC_THR = 8;
  localparam int F_RET = 16;
  localparam int F_PROT = 24;

  // status register fields
  localparam int F_LEVEL = 0;
  localparam int F_VIEW = 2;
  localparam int F_PARAM = 4;
  localparam int F_GREEN = 8;
  localparam int F_RED = 9;
  localparam int F_BLINK = 10;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // level indicator characters
  localparam logic [3:0] CHAR_NONE = 4'h0;
  localparam logic [3:0] CHAR_INIT = 4'h5;
  localparam logic [3:0] CHAR_ADV = 4'hf;
  localparam logic [3:0] CHAR_PROT = 4'hc;

  typedef enum logic [1:0] {LVL_OP, LVL_INIT, LVL_ADV, LVL_PROT} level_t;
  typedef enum logic [1:0] {VIEW_NAME, VIEW_VALUE, VIEW_CHANGE} view_t;
  typedef enum logic [2:0] {P_ZC_EN, P_ZC_THR, P_COLOR, P_RET, P_PROT,
    P_PASS} param_t;
  typedef enum logic [1:0] {COL_GREEN_RED, COL_GREEN, COL_RED_GREEN,
    COL_RED} color_t;

  typedef struct packed {
    logic zc_en;
    logic [6:0] zc_thr;
    color_t color;
    logic [6:0] ret;
    logic [4:0] prot;
  } settings_t;

  localparam settings_t SETTINGS_RST = '{1'b0, 7'h00, COL_GREEN_RED,
    7'h00, 5'h05};

  typedef struct packed {
    logic mode;
    logic shift;
    logic up;
  } keys_t;

  typedef struct packed {
    logic awvalid;
    logic [11:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [11:0] araddr;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;

endpackage : panel_pkg

// file: panel_setting_menu_control.sv
/*
  front-panel setting menu: key levels, five advanced settings, zero clamp,
  indicator colour, idle return and protect-level entry; axi4-lite slave.
  assumes key pins are asynchronous and active high, process value and
  comparative output come from logic on clk_sys, and nv storage outside.
*/
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module panel_setting_menu_control #(
  parameter int MS_CYCLES = panel_pkg::MS_CYCLES_DEF,
  parameter logic signed [15:0] PASSWORD = 16'shff57
)(
  input wire logic clk_sys,
  input wire logic rst,
  input wire panel_pkg::axi_req_t axi_req,
  output panel_pkg::axi_rsp_t axi_rsp,
  input wire panel_pkg::keys_t key_pins,
  input wire logic signed [15:0] process_value,
  input wire logic comp_out,
  input wire panel_pkg::settings_t nv_settings,
  output panel_pkg::settings_t settings,
  output logic nv_store,
  output logic signed [15:0] disp_value,
  output logic disp_green,
  output logic disp_red,
  output logic disp_blink,
  output logic [3:0] level_char,
  output panel_pkg::level_t level
);

  function automatic logic signed [15:0] value_of(
    panel_pkg::param_t p, panel_pkg::settings_t s);
    unique case (p)
      panel_pkg::P_ZC_EN: value_of = {15'h0000, s.zc_en};
      panel_pkg::P_ZC_THR: value_of = {9'h000, s.zc_thr};
      panel_pkg::P_COLOR: value_of = {14'h0000, s.color};
      panel_pkg::P_RET: value_of = {9'h000, s.ret};
      panel_pkg::P_PROT: value_of = {11'h000, s.prot};
      default: value_of = 16'h0000;
    endcase
  endfunction : value_of

  function automatic logic signed [15:0] max_of(panel_pkg::param_t p);
    unique case (p)
      panel_pkg::P_ZC_EN: max_of = 16'h0001;
      panel_pkg::P_ZC_THR: max_of = 16'(panel_pkg::ZC_THR_MAX);
      panel_pkg::P_COLOR: max_of = 16'h0003;
      panel_pkg::P_RET: max_of = 16'(panel_pkg::RET_MAX);
      panel_pkg::P_PROT: max_of = 16'(panel_pkg::PROT_MAX);
      default: max_of = 16'(panel_pkg::PASS_MAX);
    endcase
  endfunction : max_of

  function automatic logic [6:0] sat7(logic [6:0] v, int lim);
    sat7 = (v > 7'(lim)) ? 7'(lim) : v;
  endfunction : sat7

  function automatic panel_pkg::settings_t clean(panel_pkg::settings_t s);
    clean = s;
    clean.zc_thr = sat7(s.zc_thr, panel_pkg::ZC_THR_MAX);
    clean.ret = sat7(s.ret, panel_pkg::RET_MAX);
    clean.prot = (s.prot > 5'(panel_pkg::PROT_MAX)) ?
      5'(panel_pkg::PROT_MAX) : s.prot;
  endfunction : clean

  function automatic logic [31:0] pack_settings(panel_pkg::settings_t s);
    pack_settings = 32'h00000000;
    pack_settings[panel_pkg::F_ZC_EN] = s.zc_en;
    pack_settings[panel_pkg::F_COLOR +: 2] = s.color;
    pack_settings[panel_pkg::F_ZC_THR +: 7] = s.zc_thr;
    pack_settings[panel_pkg::F_RET +: 7] = s.ret;
    pack_settings[panel_pkg::F_PROT +: 5] = s.prot;
  endfunction : pack_settings

  // key synchronisers and edges
  panel_pkg::keys_t key_meta;
  panel_pkg::keys_t key_sync;
  panel_pkg::keys_t key_prev;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      key_meta <= '0;
      key_sync <= '0;
      key_prev <= '0;
    end
    else
    begin
      key_meta <= key_pins;
      key_sync <= key_meta;
      key_prev <= key_sync;
    end
  end

  logic key_change;
  logic mode_rel;
  logic shift_press;
  logic up_press;
  assign key_change = (key_sync != key_prev);
  assign mode_rel = !key_sync.mode && key_prev.mode;
  assign shift_press = key_sync.shift && !key_prev.shift;
  assign up_press = key_sync.up && !key_prev.up;

  // millisecond time base
  logic [17:0] ms_div;
  logic ms_tick;
  assign ms_tick = (ms_div == 18'(MS_CYCLES - 1));
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ms_div <= 18'h00000;
    else if (ms_tick)
      ms_div <= 18'h00000;
    else
      ms_div <= ms_div + 18'h00001;
  end

  // time since last key change, restarted per press or release
  logic [16:0] since_ms;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      since_ms <= 17'h00000;
    else if (key_change)
      since_ms <= 17'h00000;
    else if (ms_tick && since_ms != 17'h1ffff)
      since_ms <= since_ms + 17'h00001;
  end

  // sampling of process value and comparative output
  logic [7:0] samp_ms;
  logic signed [15:0] pv_sample;
  logic comp_sample;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      samp_ms <= 8'h00;
      pv_sample <= 16'sh0000;
      comp_sample <= 1'b0;
    end
    else if (ms_tick)
    begin
      if (samp_ms == 8'(panel_pkg::SAMPLE_MS - 1))
      begin
        samp_ms <= 8'h00;
        pv_sample <= process_value;
        comp_sample <= comp_out;
      end
      else
        samp_ms <= samp_ms + 8'h01;
    end
  end

  // menu decisions
  panel_pkg::view_t view;
  panel_pkg::param_t param;
  logic signed [15:0] edit;
  logic hold_fired;
  logic [16:0] ret_ms;
  logic [16:0] prot_ms;
  logic mode_short;
  logic mode_only;
  logic auto_ret;
  logic commit;
  assign ret_ms = 17'(settings.ret) * 17'(panel_pkg::SEC_MS);
  assign prot_ms = ((settings.prot == 5'h00) ? 17'h00001 :
    17'(settings.prot)) * 17'(panel_pkg::SEC_MS);
  assign mode_short = mode_rel && !hold_fired;
  assign mode_only = (key_sync == panel_pkg::keys_t'(3'b100)) && !hold_fired;
  assign auto_ret = (settings.ret != 7'h00) && (key_sync == '0) &&
    (since_ms == ret_ms) && (level != panel_pkg::LVL_OP);
  assign commit = (level == panel_pkg::LVL_ADV) &&
    (view == panel_pkg::VIEW_CHANGE) && (mode_short || auto_ret);

  function automatic panel_pkg::param_t next_param(panel_pkg::param_t p,
    logic en);
    unique case (p)
      panel_pkg::P_ZC_EN: next_param = en ? panel_pkg::P_ZC_THR :
        panel_pkg::P_COLOR;
      panel_pkg::P_ZC_THR: next_param = panel_pkg::P_COLOR;
      panel_pkg::P_COLOR: next_param = panel_pkg::P_RET;
      panel_pkg::P_RET: next_param = panel_pkg::P_PROT;
      default: next_param = panel_pkg::P_ZC_EN;
    endcase
  endfunction : next_param

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      level <= panel_pkg::LVL_OP;
      view <= panel_pkg::VIEW_NAME;
      param <= panel_pkg::P_PASS;
      edit <= 16'sh0000;
      hold_fired <= 1'b0;
    end
    else if (auto_ret)
    begin
      level <= panel_pkg::LVL_OP;
      view <= panel_pkg::VIEW_NAME;
    end
    else if (key_change && key_sync.mode && !key_prev.mode)
      hold_fired <= 1'b0;
    else if (mode_only && level == panel_pkg::LVL_OP &&
      since_ms == 17'(panel_pkg::INIT_HOLD_MS))
    begin
      level <= panel_pkg::LVL_INIT;
      view <= panel_pkg::VIEW_NAME;
      param <= panel_pkg::P_PASS;
      edit <= 16'sh0000;
      hold_fired <= 1'b1;
    end
    else if (mode_only && level != panel_pkg::LVL_OP &&
      since_ms == 17'(panel_pkg::BACK_HOLD_MS))
    begin
      level <= (level == panel_pkg::LVL_ADV) ? panel_pkg::LVL_INIT :
        panel_pkg::LVL_OP;
      view <= panel_pkg::VIEW_NAME;
      param <= panel_pkg::P_PASS;
      hold_fired <= 1'b1;
    end
    else if (level == panel_pkg::LVL_OP && key_sync.shift && key_sync.up &&
      !key_sync.mode && since_ms == prot_ms)
      level <= panel_pkg::LVL_PROT;
    else if (level == panel_pkg::LVL_INIT || level == panel_pkg::LVL_ADV)
    begin
      if (shift_press && view == panel_pkg::VIEW_NAME)
      begin
        view <= panel_pkg::VIEW_VALUE;
        if (level == panel_pkg::LVL_ADV)
          edit <= value_of(param, settings);
      end
      else if (shift_press && view == panel_pkg::VIEW_VALUE)
        view <= panel_pkg::VIEW_CHANGE;
      else if (up_press && view == panel_pkg::VIEW_CHANGE)
      begin
        if (edit == max_of(param))
          edit <= (param == panel_pkg::P_PASS) ?
            16'(panel_pkg::PASS_MIN) : 16'sh0000;
        else
          edit <= edit + 16'sh0001;
      end
      else if (mode_short && level == panel_pkg::LVL_INIT)
      begin
        view <= panel_pkg::VIEW_NAME;
        if (view == panel_pkg::VIEW_CHANGE && edit == PASSWORD)
        begin
          level <= panel_pkg::LVL_ADV;
          param <= panel_pkg::P_ZC_EN;
        end
      end
      else if (mode_short)
      begin
        view <= panel_pkg::VIEW_NAME;
        param <= next_param(param, (param == panel_pkg::P_ZC_EN &&
          view == panel_pkg::VIEW_CHANGE) ? edit[0] : settings.zc_en);
      end
    end
  end

  // axi4-lite slave
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_go;
  logic [31:0] status_word;
  assign wr_go = !axi_rsp.awready && !axi_rsp.wready && !axi_rsp.bvalid;
  always_comb
  begin
    status_word = 32'h00000000;
    status_word[panel_pkg::F_LEVEL +: 2] = level;
    status_word[panel_pkg::F_VIEW +: 2] = view;
    status_word[panel_pkg::F_PARAM +: 3] = param;
    status_word[panel_pkg::F_GREEN] = disp_green;
    status_word[panel_pkg::F_RED] = disp_red;
    status_word[panel_pkg::F_BLINK] = disp_blink;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      axi_rsp <= '0;
      axi_rsp.awready <= 1'b1;
      axi_rsp.wready <= 1'b1;
      axi_rsp.arready <= 1'b1;
      wr_addr <= 12'h000;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end
    else
    begin
      if (axi_req.awvalid && axi_rsp.awready)
      begin
        wr_addr <= axi_req.awaddr;
        axi_rsp.awready <= 1'b0;
      end
      if (axi_req.wvalid && axi_rsp.wready)
      begin
        wr_data <= axi_req.wdata;
        wr_strb <= axi_req.wstrb;
        axi_rsp.wready <= 1'b0;
      end
      if (wr_go)
      begin
        axi_rsp.bvalid <= 1'b1;
        unique case ({wr_addr[11:2], 2'b00})
          panel_pkg::SETTINGS_OFS,
          panel_pkg::STATUS_OFS,
          panel_pkg::VALUE_OFS: axi_rsp.bresp <= panel_pkg::RESP_OKAY;
          default: axi_rsp.bresp <= panel_pkg::RESP_SLVERR;
        endcase
      end
      if (axi_rsp.bvalid && axi_req.bready)
      begin
        axi_rsp.bvalid <= 1'b0;
        axi_rsp.awready <= 1'b1;
        axi_rsp.wready <= 1'b1;
      end
      if (axi_req.arvalid && axi_rsp.arready)
      begin
        axi_rsp.arready <= 1'b0;
        axi_rsp.rvalid <= 1'b1;
        axi_rsp.rresp <= panel_pkg::RESP_OKAY;
        unique case ({axi_req.araddr[11:2], 2'b00})
          panel_pkg::SETTINGS_OFS: axi_rsp.rdata <= pack_settings(settings);
          panel_pkg::STATUS_OFS: axi_rsp.rdata <= status_word;
          panel_pkg::VALUE_OFS: axi_rsp.rdata <= 32'(disp_value);
          default:
          begin
            axi_rsp.rdata <= 32'h00000000;
            axi_rsp.rresp <= panel_pkg::RESP_SLVERR;
          end
        endcase
      end
      if (axi_rsp.rvalid && axi_req.rready)
      begin
        axi_rsp.rvalid <= 1'b0;
        axi_rsp.arready <= 1'b1;
      end
    end
  end

  // settings store, restore from nv storage after reset
  logic restored;
  logic sw_write;
  logic [31:0] lane_mask;
  logic [31:0] merged;
  panel_pkg::settings_t from_bus;
  panel_pkg::settings_t from_menu;
  assign sw_write = wr_go &&
    ({wr_addr[11:2], 2'b00} == panel_pkg::SETTINGS_OFS);
  assign lane_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}},
    {8{wr_strb[0]}}};
  assign merged = (pack_settings(settings) & ~lane_mask) |
    (wr_data & lane_mask);
  always_comb
  begin
    from_bus = settings;
    from_bus.zc_en = merged[panel_pkg::F_ZC_EN];
    from_bus.color = panel_pkg::color_t'(merged[panel_pkg::F_COLOR +: 2]);
    from_bus.zc_thr = merged[panel_pkg::F_ZC_THR +: 7];
    from_bus.ret = merged[panel_pkg::F_RET +: 7];
    from_bus.prot = merged[panel_pkg::F_PROT +: 5];
    from_menu = settings;
    unique case (param)
      panel_pkg::P_ZC_EN: from_menu.zc_en = edit[0];
      panel_pkg::P_ZC_THR: from_menu.zc_thr = edit[6:0];
      panel_pkg::P_COLOR: from_menu.color = panel_pkg::color_t'(edit[1:0]);
      panel_pkg::P_RET: from_menu.ret = edit[6:0];
      panel_pkg::P_PROT: from_menu.prot = edit[4:0];
      default: from_menu = settings;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      settings <= panel_pkg::SETTINGS_RST;
      restored <= 1'b0;
      nv_store <= 1'b0;
    end
    else if (!restored)
    begin
      settings <= clean(nv_settings);
      restored <= 1'b1;
      nv_store <= 1'b0;
    end
    else
    begin
      nv_store <= commit || sw_write;
      if (commit)
        settings <= clean(from_menu);
      else if (sw_write)
        settings <= clean(from_bus);
    end
  end

  // indicator outputs
  logic show_edit;
  assign show_edit = (view != panel_pkg::VIEW_NAME) &&
    (level == panel_pkg::LVL_INIT || level == panel_pkg::LVL_ADV);
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      disp_value <= 16'sh0000;
      disp_blink <= 1'b0;
      level_char <= panel_pkg::CHAR_NONE;
    end
    else
    begin
      if (show_edit)
        disp_value <= edit;
      else if (settings.zc_en &&
        pv_sample < $signed({9'h000, settings.zc_thr}))
        disp_value <= 16'sh0000;
      else
        disp_value <= pv_sample;
      disp_blink <= show_edit && (view == panel_pkg::VIEW_CHANGE);
      unique case (level)
        panel_pkg::LVL_OP: level_char <= panel_pkg::CHAR_NONE;
        panel_pkg::LVL_INIT: level_char <= panel_pkg::CHAR_INIT;
        panel_pkg::LVL_ADV: level_char <= panel_pkg::CHAR_ADV;
        panel_pkg::LVL_PROT: level_char <= panel_pkg::CHAR_PROT;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      disp_green <= 1'b1;
      disp_red <= 1'b0;
    end
    else
    begin
      unique case (settings.color)
        panel_pkg::COL_GREEN_RED: disp_green <= !comp_sample;
        panel_pkg::COL_RED_GREEN: disp_green <= comp_sample;
        panel_pkg::COL_GREEN: disp_green <= 1'b1;
        panel_pkg::COL_RED: disp_green <= 1'b0;
      endcase
      unique case (settings.color)
        panel_pkg::COL_GREEN_RED: disp_red <= comp_sample;
        panel_pkg::COL_RED_GREEN: disp_red <= !comp_sample;
        panel_pkg::COL_GREEN: disp_red <= 1'b0;
        panel_pkg::COL_RED: disp_red <= 1'b1;
      endcase
    end
  end

endmodule : panel_setting_menu_control

// file: panel_chk.sv
/*
  concurrent checks on the panel setting menu ports.
  assumes one clock domain and the top module's ports only.
*/
`timescale 1ns/1ps
module panel_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire panel_pkg::axi_req_t axi_req,
  input wire panel_pkg::axi_rsp_t axi_rsp,
  input wire panel_pkg::keys_t key_pins,
  input wire panel_pkg::settings_t settings,
  input wire logic nv_store,
  input wire logic disp_green,
  input wire logic disp_red,
  input wire logic [3:0] level_char,
  input wire panel_pkg::level_t level
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_to_init;
    level == panel_pkg::LVL_OP ##1 level == panel_pkg::LVL_INIT;
  endsequence
  sequence s_to_prot;
    level == panel_pkg::LVL_OP ##1 level == panel_pkg::LVL_PROT;
  endsequence
  AST_ENTER_INIT: assert property (s_to_init |->
    $past(key_pins.mode, 4)) else $error("init without mode hold");
  AST_ENTER_PROT: assert property (s_to_prot |->
    $past(key_pins.shift, 4) && $past(key_pins.up, 4))
    else $error("protect without key pair");
  AST_INIT_CHAR: assert property (level == panel_pkg::LVL_INIT [*2] |->
    level_char == panel_pkg::CHAR_INIT) else $error("init char wrong");
  AST_ONE_COLOUR: assert property (disp_green != disp_red)
    else $error("indicator colour not single");
  AST_NV_PULSE: assert property (nv_store |=> !nv_store)
    else $error("store pulse too long");
  AST_THR_RANGE: assert property (settings.zc_thr <= 7'h63)
    else $error("threshold out of range");
  AST_RET_RANGE: assert property (settings.ret <= 7'h63)
    else $error("return time out of range");
  AST_PROT_RANGE: assert property (settings.prot <= 5'h13)
    else $error("protect time out of range");
  AST_RD_ANSWER: assert property (axi_req.arvalid && axi_rsp.arready
    |=> axi_rsp.rvalid) else $error("read answer late");
endmodule : panel_chk
bind panel_setting_menu_control panel_chk chk_i (.clk_sys(clk_sys),
  .rst(rst), .axi_req(axi_req), .axi_rsp(axi_rsp), .key_pins(key_pins),
  .settings(settings), .nv_store(nv_store), .disp_green(disp_green),
  .disp_red(disp_red), .level_char(level_char), .level(level));

// file: key_operator.sv
/*
  front-panel operator: presses a key set for a number of clocks.
  assumes keys change only after a rising clock edge.
*/
`timescale 1ns/1ps
module key_operator (
  input wire logic clk_sys,
  output panel_pkg::keys_t key_pins
);
  initial key_pins = '0;
  // press, hold, release, then pause before the next press
  task hold(input panel_pkg::keys_t k, input int n);
    @(posedge clk_sys);
    key_pins <= k;
    repeat (n) @(posedge clk_sys);
    key_pins <= '0;
    repeat (8) @(posedge clk_sys);
  endtask : hold
endmodule : key_operator

// file: testbench.sv
/*
  self-checking bench of the panel setting menu.
  assumes a 4-clock millisecond and a short password of 2.
*/
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  panel_pkg::axi_req_t req = '0;
  panel_pkg::axi_rsp_t rsp;
  panel_pkg::keys_t keys;
  logic signed [15:0] pv = 16'sh0000;
  logic comp = 1'b0;
  panel_pkg::settings_t nv = '{1'b1, 7'h0a, panel_pkg::COL_GREEN_RED,
    7'h00, 5'h00};
  panel_pkg::settings_t st;
  logic nv_store;
  logic green;
  logic red;
  logic blink;
  logic signed [15:0] dv;
  logic [3:0] lchar;
  panel_pkg::level_t lvl;
  logic [31:0] q;
  logic [1:0] r;
  int mismatches = 0;
  int cmp_count = 0;
  int nv_pulses = 0;
  always @(posedge clk_sys)
    if (nv_store === 1'b1)
      nv_pulses <= nv_pulses + 1;
  always #2.5 clk_sys = ~clk_sys;
  panel_setting_menu_control #(.MS_CYCLES(4), .PASSWORD(16'sh0002)) dut (
    .clk_sys(clk_sys), .rst(rst), .axi_req(req), .axi_rsp(rsp),
    .key_pins(keys), .process_value(pv), .comp_out(comp),
    .nv_settings(nv), .settings(st), .nv_store(nv_store),
    .disp_value(dv), .disp_green(green), .disp_red(red),
    .disp_blink(blink), .level_char(lchar), .level(lvl));
  key_operator op (.clk_sys(clk_sys), .key_pins(keys));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task axi(input bit wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req.awvalid <= wr;
    req.wvalid <= wr;
    req.bready <= wr;
    req.arvalid <= !wr;
    req.rready <= !wr;
    req.awaddr <= a;
    req.araddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    do
    begin
      @(posedge clk_sys);
      if (rsp.awready)
        req.awvalid <= 1'b0;
      if (rsp.wready)
        req.wvalid <= 1'b0;
      if (rsp.arready)
        req.arvalid <= 1'b0;
    end
    while (rsp.bvalid !== 1'b1 && rsp.rvalid !== 1'b1);
    q = rsp.rdata;
    r = wr ? rsp.bresp : rsp.rresp;
    req.bready <= 1'b0;
    req.rready <= 1'b0;
  endtask : axi

  task sample(input logic signed [15:0] v, input logic c);
    @(posedge clk_sys);
    pv <= v;
    comp <= c;
    repeat (1010) @(posedge clk_sys);
  endtask : sample

  task t_boot;
    axi(0, panel_pkg::SETTINGS_OFS, 32'h0);
    chk(q, 32'h00000a01);
    chk(st, nv);
    axi(0, 12'h00c, 32'h0);
    chk(r, panel_pkg::RESP_SLVERR);
    chk(q, 32'h0);
    axi(1, 12'h00c, 32'h0);
    chk(r, panel_pkg::RESP_SLVERR);
    $display("boot test done");
  endtask : t_boot

  task t_menu;
    op.hold(3'b100, 12010);
    chk(lvl, panel_pkg::LVL_INIT);
    chk(lchar, panel_pkg::CHAR_INIT);
    repeat (2) op.hold(3'b010, 8);
    chk(blink, 1'b1);
    repeat (2) op.hold(3'b001, 8);
    op.hold(3'b100, 8);
    chk(lvl, panel_pkg::LVL_ADV);
    op.hold(3'b010, 8);
    chk(dv, 32'h1);
    op.hold(3'b010, 8);
    op.hold(3'b001, 8);
    chk(dv, 32'h0);
    op.hold(3'b100, 8);
    chk(st.zc_en, 1'b0);
    axi(0, panel_pkg::STATUS_OFS, 32'h0);
    chk(q[6:4], panel_pkg::P_COLOR);
    op.hold(3'b100, 4010);
    chk(lvl, panel_pkg::LVL_INIT);
    op.hold(3'b100, 4010);
    chk(lvl, panel_pkg::LVL_OP);
    $display("menu test done");
  endtask : t_menu

  task t_zero;
    axi(1, panel_pkg::SETTINGS_OFS, 32'h00000a01);
    chk(r, panel_pkg::RESP_OKAY);
    sample(16'sh0005, 1'b0);
    chk(dv, 32'h0);
    sample(16'sh000a, 1'b0);
    chk(dv, 32'h0000000a);
    axi(1, panel_pkg::SETTINGS_OFS, 32'h1f7f7f00);
    axi(0, panel_pkg::SETTINGS_OFS, 32'h0);
    chk(q, 32'h13636300);
    axi(1, panel_pkg::SETTINGS_OFS, 32'h00000a00);
    sample(16'sh0005, 1'b0);
    chk(dv, 32'h00000005);
    sample(16'shfffd, 1'b0);
    axi(0, panel_pkg::VALUE_OFS, 32'h0);
    chk(q, 32'hfffffffd);
    $display("zero clamp test done");
  endtask : t_zero

  task t_color;
    logic g;
    for (int c = 0; c < 4; c++)
      for (int k = 0; k < 2; k++)
      begin
        axi(1, panel_pkg::SETTINGS_OFS, {26'h0, c[1:0], 4'h0});
        sample(16'sh0005, k[0]);
        g = (c == 1) || (c == 0 && k == 0) || (c == 2 && k == 1);
        chk({green, red}, {g, !g});
      end
    $display("colour test done");
  endtask : t_color

  task t_protect;
    op.hold(3'b011, 3000);
    chk(lvl, panel_pkg::LVL_OP);
    op.hold(3'b011, 4100);
    chk(lvl, panel_pkg::LVL_PROT);
    op.hold(3'b100, 4010);
    chk(lvl, panel_pkg::LVL_OP);
    $display("protect test done");
  endtask : t_protect

  task t_idle;
    axi(1, panel_pkg::SETTINGS_OFS, 32'h00010000);
    op.hold(3'b100, 12010);
    repeat (3900) @(posedge clk_sys);
    chk(lvl, panel_pkg::LVL_INIT);
    repeat (200) @(posedge clk_sys);
    chk(lvl, panel_pkg::LVL_OP);
    $display("idle return test done");
  endtask : t_idle

  task t_edit_idle;
    int n;
    op.hold(3'b100, 12010);
    repeat (2) op.hold(3'b010, 8);
    repeat (2) op.hold(3'b001, 8);
    op.hold(3'b100, 8);
    chk(lvl, panel_pkg::LVL_ADV);
    n = nv_pulses;
    repeat (2) op.hold(3'b010, 8);
    op.hold(3'b001, 8);
    repeat (4100) @(posedge clk_sys);
    chk(st.zc_en, 1'b1);
    chk(lvl, panel_pkg::LVL_OP);
    chk(nv_pulses, n + 1);
    $display("edit idle return test done");
  endtask : t_edit_idle

  task stop_test;
    $display("%0d mismatches in %0d checks", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_boot();
    t_menu();
    t_zero();
    t_color();
    t_protect();
    t_idle();
    t_edit_idle();
    stop_test();
  end

  initial
  begin
    #450000;
    mismatches++;
    stop_test();
  end
endmodule : testbench
